// *** rtl/cmo_consts.svh ***
`ifndef CMO_CONSTS_SVH
`define CMO_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CMO_ADDR_W 30
`define CMO_DATA_W 32
`define CMO_BE_W 4
`define CMO_THR_W 2
`define CMO_ENTRY_W 36

// ----------------------------------------
// Store buffer geometry
// ----------------------------------------
`define CMO_SB_DEPTH 4
`define CMO_PTR_W 2
`define CMO_CNT_W 3
`define CMO_CNT_FULL 3'h4
`define CMO_PTR_STEP 2'h1
`define CMO_CNT_STEP 3'h1

// ----------------------------------------
// Byte lanes, little-endian
// ----------------------------------------
`define CMO_LANE3_MSB 31
`define CMO_LANE3_LSB 24

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMO_PTR_RST 2'h0
`define CMO_CNT_RST 3'h0
`define CMO_VALID_RST 4'h0
`define CMO_ADDR_RST 30'h0
`define CMO_DATA_RST 32'h0
`define CMO_THR_RST 2'h0

`endif

// *** rtl/cmo_pkg.sv ***
package cmo_pkg;

    // ----------------------------------------
    // Request kinds from the thread side
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        op_nop = 2'b00,
        op_load = 2'b01,
        op_store = 2'b10,
        op_barrier = 2'b11
    } cmo_op_t;

    // ----------------------------------------
    // Load path states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        ld_idle = 2'b00,
        ld_req = 2'b01,
        ld_wait = 2'b10,
        ld_resp = 2'b11
    } cmo_ld_state_t;

    // ----------------------------------------
    // Store drain states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        dr_idle = 2'b00,
        dr_issue = 2'b01,
        dr_ack = 2'b10
    } cmo_dr_state_t;

endpackage : cmo_pkg

// *** rtl/cmo_store_mem.sv ***
`timescale 1ns/1ps
`include "cmo_consts.svh"

module cmo_store_mem
(
    // Clock
    input logic clock_i,
    // Write port
    input logic wr_en_i,
    input logic [`CMO_PTR_W-1:0] wr_idx_i,
    input logic [`CMO_ENTRY_W-1:0] wr_data_i,
    // Read port, data one cycle later
    input logic rd_en_i,
    input logic [`CMO_PTR_W-1:0] rd_idx_i,
    output logic [`CMO_ENTRY_W-1:0] rd_data_o
);

    logic [`CMO_ENTRY_W-1:0] mem [`CMO_SB_DEPTH];

    always_ff @(posedge clock_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_idx_i] <= wr_data_i;
        end
    end

    // No reset: contents are only read after a write
    always_ff @(posedge clock_i)
    begin
        if (rd_en_i)
        begin
            rd_data_o <= mem[rd_idx_i];
        end
    end

endmodule : cmo_store_mem

// *** rtl/cmo_order_unit.sv ***
`timescale 1ns/1ps
`include "cmo_consts.svh"

module cmo_order_unit
    import cmo_pkg::*;
(
    // Clock and reset
    input logic clock_i,
    input logic reset_n_i,
    // Thread side requests
    input logic req_valid_i,
    input cmo_op_t req_op_i,
    input logic [`CMO_THR_W-1:0] req_thread_i,
    input logic [`CMO_ADDR_W-1:0] req_addr_i,
    input logic [`CMO_BE_W-1:0] req_be_i,
    input logic [`CMO_DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    // Thread side load answers
    output logic rsp_valid_o,
    output logic [`CMO_THR_W-1:0] rsp_thread_o,
    output logic [`CMO_DATA_W-1:0] rsp_rdata_o,
    // Coherent interconnect, stores
    output logic wr_valid_o,
    output logic [`CMO_ADDR_W-1:0] wr_addr_o,
    output logic [`CMO_BE_W-1:0] wr_be_o,
    output logic [`CMO_DATA_W-1:0] wr_data_o,
    input logic wr_ready_i,
    input logic wr_ack_i,
    // Coherent interconnect, loads
    output logic rd_valid_o,
    output logic [`CMO_ADDR_W-1:0] rd_addr_o,
    input logic rd_ready_i,
    input logic rd_rvalid_i,
    input logic [`CMO_DATA_W-1:0] rd_rdata_i,
    // Status
    output logic sb_empty_o
);

    // ----------------------------------------
    // Store buffer bookkeeping
    // ----------------------------------------
    logic [`CMO_SB_DEPTH-1:0] sb_valid;
    logic [`CMO_SB_DEPTH-1:0][`CMO_ADDR_W-1:0] sb_addr;
    logic [`CMO_PTR_W-1:0] wptr;
    logic [`CMO_PTR_W-1:0] rptr;
    logic [`CMO_CNT_W-1:0] count;
    logic [`CMO_CNT_W-1:0] next_count;
    logic [`CMO_ENTRY_W-1:0] mem_rd_data;
    cmo_ld_state_t ld_state;
    cmo_dr_state_t dr_state;
    logic push;
    logic pop;
    logic ld_take;
    logic bar_take;
    logic req_hit;

    // Word match also catches partially overlapping byte stores
    function automatic logic cmo_hit(
        input logic [`CMO_ADDR_W-1:0] a,
        input logic [`CMO_SB_DEPTH-1:0] v,
        input logic [`CMO_SB_DEPTH-1:0][`CMO_ADDR_W-1:0] tab
    );
        logic h;
        h = 1'b0;
        for (int i = 0; i < `CMO_SB_DEPTH; i++)
        begin
            h = h | (v[i] && (tab[i] == a));
        end
        return h;
    endfunction : cmo_hit

    assign req_hit = cmo_hit(req_addr_i, sb_valid, sb_addr);

    // ----------------------------------------
    // Request acceptance
    // ----------------------------------------
    // Whole front stalls while a load is open: a younger store may depend on it
    always_comb
    begin
        req_ready_o = 1'b0;
        if (ld_state == ld_idle)
        begin
            case (req_op_i)
                op_load: req_ready_o = !req_hit;
                op_store: req_ready_o = (count != `CMO_CNT_FULL);
                op_barrier: req_ready_o = (count == `CMO_CNT_RST);
                default: req_ready_o = 1'b1;
            endcase
        end
    end

    assign push = req_valid_i && req_ready_o && (req_op_i == op_store);
    assign ld_take = req_valid_i && req_ready_o && (req_op_i == op_load);
    assign bar_take = req_valid_i && req_ready_o && (req_op_i == op_barrier);
    // Entries leave only on the all-agent acknowledge, so count==0 means visible
    assign pop = (dr_state == dr_ack) && wr_ack_i;
    assign sb_empty_o = (count == `CMO_CNT_RST);

    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + `CMO_CNT_STEP;
        end
        else if (pop && !push)
        begin
            next_count = count - `CMO_CNT_STEP;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count <= `CMO_CNT_RST;
            wptr <= `CMO_PTR_RST;
            rptr <= `CMO_PTR_RST;
        end
        else
        begin
            count <= next_count;
            if (push)
            begin
                wptr <= wptr + `CMO_PTR_STEP;
            end
            if (pop)
            begin
                rptr <= rptr + `CMO_PTR_STEP;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sb_valid <= `CMO_VALID_RST;
        end
        else
        begin
            for (int i = 0; i < `CMO_SB_DEPTH; i++)
            begin
                if (push && (wptr == i[`CMO_PTR_W-1:0]))
                begin
                    sb_valid[i] <= 1'b1;
                end
                else if (pop && (rptr == i[`CMO_PTR_W-1:0]))
                begin
                    sb_valid[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            sb_addr[wptr] <= req_addr_i;
        end
    end

    cmo_store_mem cmo_store_mem_i
    (
        .clock_i(clock_i),
        .wr_en_i(push),
        .wr_idx_i(wptr),
        .wr_data_i({req_be_i, req_wdata_i}),
        .rd_en_i((dr_state == dr_idle) && (count != `CMO_CNT_RST)),
        .rd_idx_i(rptr),
        .rd_data_o(mem_rd_data)
    );

    // ----------------------------------------
    // Store drain, one store in flight
    // ----------------------------------------
    // Serialising on the ack trades bandwidth for one global store order
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            dr_state <= dr_idle;
        end
        else
        begin
            case (dr_state)
                dr_idle:
                begin
                    if (count != `CMO_CNT_RST)
                    begin
                        dr_state <= dr_issue;
                    end
                end
                dr_issue:
                begin
                    if (wr_ready_i)
                    begin
                        dr_state <= dr_ack;
                    end
                end
                dr_ack:
                begin
                    if (wr_ack_i)
                    begin
                        dr_state <= dr_idle;
                    end
                end
                default: dr_state <= dr_idle;
            endcase
        end
    end

    assign wr_valid_o = (dr_state == dr_issue);
    assign wr_addr_o = sb_addr[rptr];
    assign wr_be_o = mem_rd_data[`CMO_ENTRY_W-1:`CMO_DATA_W];
    assign wr_data_o = mem_rd_data[`CMO_DATA_W-1:0];

    // ----------------------------------------
    // Load path, one load at a time
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ld_state <= ld_idle;
        end
        else
        begin
            case (ld_state)
                ld_idle:
                begin
                    if (ld_take)
                    begin
                        ld_state <= ld_req;
                    end
                end
                ld_req:
                begin
                    if (rd_ready_i)
                    begin
                        ld_state <= ld_wait;
                    end
                end
                ld_wait:
                begin
                    if (rd_rvalid_i)
                    begin
                        ld_state <= ld_resp;
                    end
                end
                default: ld_state <= ld_idle;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_addr_o <= `CMO_ADDR_RST;
            rsp_thread_o <= `CMO_THR_RST;
            rsp_rdata_o <= `CMO_DATA_RST;
        end
        else
        begin
            if (ld_take)
            begin
                rd_addr_o <= req_addr_i;
                rsp_thread_o <= req_thread_i;
            end
            if ((ld_state == ld_wait) && rd_rvalid_i)
            begin
                rsp_rdata_o <= rd_rdata_i;
            end
        end
    end

    assign rd_valid_o = (ld_state == ld_req);
    assign rsp_valid_o = (ld_state == ld_resp);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    barrier_drained_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        bar_take |-> (count == `CMO_CNT_RST) && (dr_state == dr_idle) && !wr_valid_o)
        else $error("barrier passed with stores not yet visible");

    barrier_dekker_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        bar_take |=> !wr_valid_o && (ld_state == ld_idle))
        else $error("barrier left a store or load open");

    load_no_pending_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        rd_valid_o |-> !cmo_hit(rd_addr_o, sb_valid, sb_addr))
        else $error("load issued over an unacknowledged same-word store");

    store_single_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (wr_valid_o && wr_ready_i) |=> !wr_valid_o [*2])
        else $error("second store issued before acknowledge");

    drain_order_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        pop |=> (rptr == $past(rptr) + `CMO_PTR_STEP) && !sb_valid[$past(rptr)])
        else $error("store buffer drained out of order");

    lane_keep_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (push && (count == `CMO_CNT_RST) && (dr_state == dr_idle)) |-> ##2 wr_valid_o
            && (wr_be_o == $past(req_be_i, 2)) && (wr_data_o == $past(req_wdata_i, 2)))
        else $error("store bytes or lanes changed on the way out");

    load_serial_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        ld_take |=> rd_valid_o && !req_ready_o)
        else $error("second request taken while a load is open");

    load_answer_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        ((ld_state == ld_wait) && rd_rvalid_i) |=> rsp_valid_o && (rsp_rdata_o == $past(rd_rdata_i)))
        else $error("load answer not the returned data");

    full_stall_a: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (count == `CMO_CNT_FULL) |-> !push)
        else $error("store accepted into a full buffer");

endmodule : cmo_order_unit

// *** sim/cmo_fabric_model.sv ***
`timescale 1ns/1ps

module cmo_fabric_model
(
    // Control
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic slow_i,
    // Stores
    input wire logic wr_valid_i,
    input wire logic [29:0] wr_addr_i,
    input wire logic [3:0] wr_be_i,
    input wire logic [31:0] wr_data_i,
    output logic wr_ready_o,
    output logic wr_ack_o,
    // Loads
    input wire logic rd_valid_i,
    input wire logic [29:0] rd_addr_i,
    output logic rd_ready_o,
    output logic rd_rvalid_o,
    output logic [31:0] rd_rdata_o
);
    // ----------------------------------------
    // Shared memory behind the interconnect
    // ----------------------------------------
    logic [31:0] mem [logic [29:0]];
    logic [2:0] tick;
    logic [2:0] wcnt;
    logic [2:0] rcnt;
    logic [29:0] waddr;
    logic [29:0] raddr;
    logic [3:0] wbe;
    logic [31:0] wdat;
    logic [31:0] cur;

    // Slow mode stalls takes and stretches answers
    assign wr_ready_o = wr_valid_i && wcnt == 3'h0 && (!slow_i || tick[1:0] == 2'h0);
    assign rd_ready_o = rd_valid_i && rcnt == 3'h0 && (!slow_i || tick[0]);

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tick <= 3'h0;
            wcnt <= 3'h0;
            rcnt <= 3'h0;
            wr_ack_o <= 1'b0;
            rd_rvalid_o <= 1'b0;
            rd_rdata_o <= 32'h0;
        end
        else
        begin
            tick <= tick + 3'h1;
            wr_ack_o <= 1'b0;
            rd_rvalid_o <= 1'b0;
            // Released data lines toggle so stale values never look valid
            rd_rdata_o <= ~rd_rdata_o;
            if (wr_valid_i && wr_ready_o)
            begin
                wcnt <= slow_i ? 3'h5 : 3'h1;
                waddr <= wr_addr_i;
                wbe <= wr_be_i;
                wdat <= wr_data_i;
            end
            else if (wcnt == 3'h1)
            begin
                // One serialization point, visible to all at the ack
                cur = mem.exists(waddr) ? mem[waddr] : 32'h0;
                for (int i = 0; i < 4; i++)
                begin
                    if (wbe[i])
                    begin
                        cur[8*i +: 8] = wdat[8*i +: 8];
                    end
                end
                mem[waddr] = cur;
                wr_ack_o <= 1'b1;
                wcnt <= 3'h0;
            end
            else if (wcnt != 3'h0)
                wcnt <= wcnt - 3'h1;
            if (rd_valid_i && rd_ready_o)
            begin
                rcnt <= slow_i ? 3'h4 : 3'h1;
                raddr <= rd_addr_i;
            end
            else if (rcnt == 3'h1)
            begin
                rd_rvalid_o <= 1'b1;
                rd_rdata_o <= mem.exists(raddr) ? mem[raddr] : 32'h0;
                rcnt <= 3'h0;
            end
            else if (rcnt != 3'h0)
                rcnt <= rcnt - 3'h1;
        end
    end
endmodule : cmo_fabric_model

// *** sim/tb_coherent_memory_ordering.sv ***
`timescale 1ns/1ps

module tb_coherent_memory_ordering;
    import cmo_pkg::*;
    // ----------------------------------------
    // Bench state
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic slow = 1'b0;
    logic req_valid_i = 1'b0;
    cmo_op_t req_op_i = op_nop;
    logic [1:0] req_thread_i = 2'h0;
    logic [29:0] req_addr_i = 30'h0;
    logic [3:0] req_be_i = 4'h0;
    logic [31:0] req_wdata_i = 32'h0;
    logic req_ready_o, rsp_valid_o, wr_valid_o, wr_ready_i, wr_ack_i;
    logic rd_valid_o, rd_ready_i, rd_rvalid_i, sb_empty_o;
    logic [1:0] rsp_thread_o;
    logic [31:0] rsp_rdata_o, wr_data_o, rd_rdata_i;
    logic [29:0] wr_addr_o, rd_addr_o;
    logic [3:0] wr_be_o;
    int failures = 0;
    int comparisons = 0;
    logic [15:0] lfsr = 16'h0010;
    logic [31:0] ref_mem [logic [29:0]];
    logic [65:0] exp_q [$];

    always #50 clock_i = ~clock_i;

    cmo_order_unit cmo_order_unit_i (.clock_i, .reset_n_i, .req_valid_i, .req_op_i, .req_thread_i,
        .req_addr_i, .req_be_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_thread_o, .rsp_rdata_o,
        .wr_valid_o, .wr_addr_o, .wr_be_o, .wr_data_o, .wr_ready_i, .wr_ack_i, .rd_valid_o, .rd_addr_o,
        .rd_ready_i, .rd_rvalid_i, .rd_rdata_i, .sb_empty_o);

    cmo_fabric_model cmo_fabric_model_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .slow_i(slow),
        .wr_valid_i(wr_valid_o), .wr_addr_i(wr_addr_o), .wr_be_i(wr_be_o), .wr_data_i(wr_data_o),
        .wr_ready_o(wr_ready_i), .wr_ack_o(wr_ack_i), .rd_valid_i(rd_valid_o), .rd_addr_i(rd_addr_o),
        .rd_ready_o(rd_ready_i), .rd_rvalid_o(rd_rvalid_i), .rd_rdata_o(rd_rdata_i));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Little-endian lane merge: enable bit i owns data byte i
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [3:0] be,
        input logic [31:0] d);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                m[8*i +: 8] = d[8*i +: 8];
            end
        end
        return m;
    endfunction : merge_bytes

    task automatic check(input string what, input logic [65:0] exp, input logic [65:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic wait_high(input bit for_rsp);
        int n;
        n = 0;
        @(negedge clock_i);
        while ((for_rsp ? rsp_valid_o : req_ready_o) !== 1'b1)
        begin
            n++;
            if (n > 300)
            begin
                failures++;
                stop_test();
            end
            @(negedge clock_i);
        end
    endtask : wait_high

    // Whole request held until taken; loads wait for their answer
    task automatic issue(input cmo_op_t op, input logic [1:0] th, input logic [29:0] a,
        input logic [3:0] be, input logic [31:0] d);
        logic [31:0] exp;
        req_valid_i = 1'b1;
        req_op_i = op;
        req_thread_i = th;
        req_addr_i = a;
        req_be_i = be;
        req_wdata_i = d;
        wait_high(1'b0);
        if (op == op_barrier) check("barrier drained", 66'h1, {65'h0, sb_empty_o});
        @(posedge clock_i);
        #1;
        req_valid_i = 1'b0;
        exp = ref_mem.exists(a) ? ref_mem[a] : 32'h0;
        if (op == op_store)
        begin
            exp_q.push_back({a, be, d});
            ref_mem[a] = merge_bytes(exp, be, d);
        end
        if (op == op_load)
        begin
            wait_high(1'b1);
            check("load data", {32'h0, th, exp}, {32'h0, rsp_thread_o, rsp_rdata_o});
        end
        // One idle edge, so valid never falls and rises in one step
        @(posedge clock_i);
        #1;
    endtask : issue

    always @(posedge clock_i)
        if (reset_n_i && wr_valid_o && wr_ready_i)
            check("store order", exp_q.size() > 0 ? exp_q.pop_front() : 66'h0,
                {wr_addr_o, wr_be_o, wr_data_o});

    initial
    begin
        repeat (4) @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        check("idle empty", 66'h1, {65'h0, sb_empty_o});
        // Byte stores to lanes 0 and 3 of one word from two threads
        issue(op_store, 2'h0, 30'h5, 4'h1, 32'h0000_0002);
        issue(op_store, 2'h1, 30'h5, 4'h8, 32'h0200_0000);
        issue(op_barrier, 2'h0, 30'h0, 4'h0, 32'h0);
        issue(op_load, 2'h0, 30'h5, 4'hf, 32'h0);
        check("lane merge", {34'h0, 32'h0200_0002}, {34'h0, rsp_rdata_o});
        // Two threads: store, barrier, load the other variable
        slow = 1'b1;
        issue(op_store, 2'h0, 30'h1, 4'hf, 32'h2);
        issue(op_store, 2'h1, 30'h2, 4'hf, 32'h2);
        issue(op_barrier, 2'h0, 30'h0, 4'h0, 32'h0);
        issue(op_load, 2'h0, 30'h2, 4'hf, 32'h0);
        issue(op_barrier, 2'h1, 30'h0, 4'h0, 32'h0);
        issue(op_load, 2'h1, 30'h1, 4'hf, 32'h0);
        // Stores one idle edge apart, past the buffer depth
        for (int k = 0; k < 6; k++)
            issue(op_store, k[1:0], 30'h8 + 30'(k), 4'hf, 32'h100 + 32'(k));
        issue(op_load, 2'h3, 30'h8, 4'hf, 32'h0);
        for (int k = 0; k < 120; k++)
        begin
            lfsr = lfsr_next(lfsr);
            slow = lfsr[9];
            issue(cmo_op_t'(lfsr[1:0]), lfsr[11:10], {28'h0, lfsr[7:6]},
                lfsr[5:2] == 4'h0 ? 4'hf : lfsr[5:2], {lfsr, ~lfsr});
        end
        issue(op_barrier, 2'h0, 30'h0, 4'h0, 32'h0);
        check("stores drained", 66'h0, {34'h0, 32'(exp_q.size())});
        stop_test();
    end
endmodule : tb_coherent_memory_ordering
